//--- rtl/ppo_pkg.sv
// Package for the pulse pattern output unit: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ppo_pkg;

   localparam int          PPO_GROUPS       = 4;
   localparam int          PPO_GROUP_BITS   = 4;
   localparam int          PPO_BITS         = 16;
   localparam int          PPO_CHANNELS     = 4;

   localparam logic [7:0]  PPO_OFS_MODE     = 8'h00;
   localparam logic [7:0]  PPO_OFS_TRIGSEL  = 8'h04;
   localparam logic [7:0]  PPO_OFS_NEXT     = 8'h08;
   localparam logic [7:0]  PPO_OFS_OUTDATA  = 8'h0C;
   localparam logic [7:0]  PPO_OFS_NDEN     = 8'h10;
   localparam logic [7:0]  PPO_OFS_DIR      = 8'h14;
   localparam logic [7:0]  PPO_OFS_CAPMODE  = 8'h18;
   localparam logic [7:0]  PPO_OFS_PINSTAT  = 8'h1C;

   localparam int          PPO_INV_LSB      = 4;
   localparam int          PPO_NOV_LSB      = 0;

   localparam logic [7:0]  PPO_MODE_RST     = 8'hF0;
   localparam logic [7:0]  PPO_TRIGSEL_RST  = 8'hFF;
   localparam logic [15:0] PPO_DATA_RST     = 16'h0000;
   localparam logic [3:0]  PPO_CAPMODE_RST  = 4'h0;

   localparam logic [1:0]  PPO_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  PPO_RESP_SLVERR  = 2'h2;

endpackage : ppo_pkg

//--- rtl/ppo_group.sv
// One four-bit pulse output group: trigger selection and next-to-output copy.
// Assumes timer strobes are one-cycle pulses on aclk.
module ppo_group
   import ppo_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] trig_sel,
   input  wire logic       nonoverlap_sel,
   input  wire logic [3:0] match_a,
   input  wire logic [3:0] match_b,
   input  wire logic [3:0] capture_a,
   input  wire logic [3:0] capture_mode,
   input  wire logic [3:0] next_bits,
   input  wire logic       sw_wr,
   input  wire logic [3:0] sw_data,
   output logic      [3:0] out_bits,
   output logic            trig_a_seen,
   output logic            trig_b_seen
);

   logic trig_a;
   logic trig_b;

   // Capture mode swaps the match A strobe for the capture strobe.
   assign trig_a = capture_mode[trig_sel]
                 ? capture_a[trig_sel]
                 : match_a[trig_sel];
   assign trig_b = nonoverlap_sel & match_b[trig_sel];
   assign trig_a_seen = trig_a;
   assign trig_b_seen = trig_b;

   // Copy happens regardless of pin use; triggers win over software writes.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_bits <= PPO_DATA_RST[3:0];
      else if (trig_a)
         out_bits <= next_bits;
      else if (trig_b)
         out_bits <= out_bits & next_bits;
      else if (sw_wr)
         out_bits <= sw_data;
   end

   a_copy_on_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      trig_a |=> out_bits == $past(next_bits))
      else $error("Output bits did not take next data at trigger A.");

   a_zero_on_b: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (trig_b && !trig_a)
      |=> out_bits == ($past(out_bits) & $past(next_bits)))
      else $error("Trigger B copied more than zero bits.");

   a_normal_no_b: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!nonoverlap_sel && !trig_a && !sw_wr) |=> $stable(out_bits))
      else $error("Normal mode output changed without trigger A.");

endmodule : ppo_group

//--- rtl/ppo_top.sv
// Pulse pattern output unit: sixteen output bits in four groups of four.
// Assumes an AXI4-Lite master and a timer giving one-cycle strobes.
// Contract
// - Mode bits 7..4 select inversion, reset one.
// - Inverted group drives complement of output data.
// - Nonoverlap bits 3..0 reset zero; match A only.
// - Nonoverlap group updates at match A or B.
// - Pin active only when direction and enable set.
// - Pin shows held output data before triggers.
// - Selected trigger copies next data to output.
// - Nonoverlap match A copies all next bits.
// - Nonoverlap match B copies only zero bits.
// - Two-bit field picks timer channel, reset three.
// - Capture-mode channel triggers on capture event.
// - Copy happens even when pin used elsewhere.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module ppo_top
   import ppo_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [3:0]  match_a,
   input  wire logic [3:0]  match_b,
   input  wire logic [3:0]  capture_a,
   output logic [15:0]      pulse_out,
   output logic [15:0]      pulse_out_en
);

   logic [7:0]  pulse_output_mode_reg;
   logic [7:0]  trigger_select_reg;
   logic [15:0] next_data_reg;
   logic [15:0] next_data_enable_reg;
   logic [15:0] port_direction_reg;
   logic [3:0]  capture_mode_reg;
   logic [15:0] output_data_reg;
   logic [7:0]  aw_addr_reg;
   logic        aw_full_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        w_full_reg;
   logic        wr_fire;
   logic        wr_hit;
   logic        rd_fire;
   logic [31:0] rd_data_next;
   logic        rd_ok_next;
   logic [15:0] drive_level;
   logic [15:0] pin_active;
   logic [3:0]  trig_a_seen;
   logic [3:0]  trig_b_seen;

   // Merges byte lanes of a write into a 16-bit register value.
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] r;
      r = old_v;
      if (strb[0])
         r[7:0] = data[7:0];
      if (strb[1])
         r[15:8] = data[15:8];
      return r;
   endfunction : merge16

   // Address and data are held separately so either may arrive first.
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign wr_fire       = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_full_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_full_reg <= 1'b0;
   end

   always_comb
   begin
      unique case (aw_addr_reg & 8'hFC)
         PPO_OFS_MODE, PPO_OFS_TRIGSEL, PPO_OFS_NEXT, PPO_OFS_OUTDATA,
         PPO_OFS_NDEN, PPO_OFS_DIR, PPO_OFS_CAPMODE:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PPO_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Control registers written by software.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pulse_output_mode_reg <= PPO_MODE_RST;
         trigger_select_reg    <= PPO_TRIGSEL_RST;
         next_data_reg         <= PPO_DATA_RST;
         next_data_enable_reg  <= PPO_DATA_RST;
         port_direction_reg    <= PPO_DATA_RST;
         capture_mode_reg      <= PPO_CAPMODE_RST;
      end
      else if (wr_fire && w_strb_reg[0])
      begin
         unique case (aw_addr_reg & 8'hFC)
            PPO_OFS_MODE:
               pulse_output_mode_reg <= w_data_reg[7:0];
            PPO_OFS_TRIGSEL:
               trigger_select_reg <= w_data_reg[7:0];
            PPO_OFS_CAPMODE:
               capture_mode_reg <= w_data_reg[3:0];
            default:
            begin
            end
         endcase
      end
      if (aresetn && wr_fire)
      begin
         unique case (aw_addr_reg & 8'hFC)
            PPO_OFS_NEXT:
               next_data_reg <= merge16(next_data_reg, w_data_reg,
                                        w_strb_reg);
            PPO_OFS_NDEN:
               next_data_enable_reg <= merge16(next_data_enable_reg,
                                               w_data_reg, w_strb_reg);
            PPO_OFS_DIR:
               port_direction_reg <= merge16(port_direction_reg,
                                             w_data_reg, w_strb_reg);
            default:
            begin
            end
         endcase
      end
   end

   // Each group owns four consecutive output bits.
   for (genvar g = 0; g < PPO_GROUPS; g++)
   begin : g_grp
      logic [15:0] sw_val;
      assign sw_val = merge16(output_data_reg, w_data_reg, w_strb_reg);
      ppo_group u_grp (
         .aclk           (aclk),
         .aresetn        (aresetn),
         .trig_sel       (trigger_select_reg[2*g +: 2]),
         .nonoverlap_sel (pulse_output_mode_reg[PPO_NOV_LSB + g]),
         .match_a        (match_a),
         .match_b        (match_b),
         .capture_a      (capture_a),
         .capture_mode   (capture_mode_reg),
         .next_bits      (next_data_reg[4*g +: 4]),
         .sw_wr          (wr_fire
                          && (aw_addr_reg & 8'hFC) == PPO_OFS_OUTDATA),
         .sw_data        (sw_val[4*g +: 4]),
         .out_bits       (output_data_reg[4*g +: 4]),
         .trig_a_seen    (trig_a_seen[g]),
         .trig_b_seen    (trig_b_seen[g])
      );
      // Clearing the select bit inverts the group's pin levels.
      assign drive_level[4*g +: 4] =
         pulse_output_mode_reg[PPO_INV_LSB + g] ? output_data_reg[4*g +: 4]
                                                : ~output_data_reg[4*g +: 4];
   end

   assign pin_active = port_direction_reg & next_data_enable_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pulse_out    <= 16'h0000;
         pulse_out_en <= 16'h0000;
      end
      else
      begin
         pulse_out    <= drive_level & pin_active;
         pulse_out_en <= pin_active;
      end
   end

   // Read path.
   always_comb
   begin
      rd_ok_next   = 1'b1;
      rd_data_next = 32'h0000_0000;
      unique case (s_axi_araddr & 8'hFC)
         PPO_OFS_MODE:
            rd_data_next[7:0] = pulse_output_mode_reg;
         PPO_OFS_TRIGSEL:
            rd_data_next[7:0] = trigger_select_reg;
         PPO_OFS_NEXT:
            rd_data_next[15:0] = next_data_reg;
         PPO_OFS_OUTDATA:
            rd_data_next[15:0] = output_data_reg;
         PPO_OFS_NDEN:
            rd_data_next[15:0] = next_data_enable_reg;
         PPO_OFS_DIR:
            rd_data_next[15:0] = port_direction_reg;
         PPO_OFS_CAPMODE:
            rd_data_next[3:0] = capture_mode_reg;
         PPO_OFS_PINSTAT:
            rd_data_next[15:0] = drive_level & pin_active;
         default:
            rd_ok_next = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= PPO_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data_next;
         s_axi_rresp  <= rd_ok_next ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   a_pin_gate: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ##1 pulse_out_en == $past(port_direction_reg & next_data_enable_reg))
      else $error("Pin enable does not follow direction and enable.");

   a_inv_level: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!pulse_output_mode_reg[PPO_INV_LSB] && pin_active[0])
      |=> pulse_out[0] == !$past(output_data_reg[0]))
      else $error("Inverted group 0 bit 0 has wrong level.");

   a_direct_level: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (pulse_output_mode_reg[PPO_INV_LSB + 3] && pin_active[15])
      |=> pulse_out[15] == $past(output_data_reg[15]))
      else $error("Direct group 3 bit 15 has wrong level.");

   a_grp0_trig: assert property (@(posedge aclk)
      disable iff (!aresetn)
      trig_a_seen[0] |=> output_data_reg[3:0] == $past(next_data_reg[3:0]))
      else $error("Group 0 missed its trigger copy.");

   a_reset_mode: assert property (@(posedge aclk)
      !aresetn |=> pulse_output_mode_reg == PPO_MODE_RST
                   && trigger_select_reg == PPO_TRIGSEL_RST)
      else $error("Mode or trigger select not at reset value.");

   // In non-overlap mode, match B on the selected channel must clear zero bits of group 1.
   a_b_only_nov: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (pulse_output_mode_reg[PPO_NOV_LSB + 1]
       && match_b[trigger_select_reg[3:2]] && !trig_a_seen[1])
      |-> trig_b_seen[1] ##1 output_data_reg[7:4]
          == ($past(output_data_reg[7:4]) & $past(next_data_reg[7:4])))
      else $error("Group 1 did not update at match B.");

endmodule : ppo_top

//--- testbench/ppo_timer_model.sv
// Timer model: turns bench requests into one-cycle match and capture strobes.
// Assumes the bench raises go for exactly one cycle for each event.
module ppo_timer_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [3:0] req_a,
   input  wire logic [3:0] req_b,
   input  wire logic [3:0] req_c,
   output logic      [3:0] match_a,
   output logic      [3:0] match_b,
   output logic      [3:0] capture_a
);
   timeunit 1ns;
   timeprecision 1ps;

   // Strobes fall back to zero on the cycle after each request.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !go)
      begin
         match_a   <= 4'h0;
         match_b   <= 4'h0;
         capture_a <= 4'h0;
      end
      else
      begin
         match_a   <= req_a;
         match_b   <= req_b;
         capture_a <= req_c;
      end
   end
endmodule : ppo_timer_model

//--- testbench/tb.sv
// Self-checking bench for the pulse pattern output unit.
// Assumes the timer model drives strobes and the bench is the bus master.
module tb import ppo_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, go;
   logic [7:0]  awaddr, araddr, mode, ts;
   logic [31:0] wdata, rdata, rnd, d, x;
   logic [1:0]  bresp, rresp, r, eb;
   logic [3:0]  ma, mb, ca, ra, rb, rc, cm;
   logic [15:0] pout, pen, od, nd, en, dir;
   int          num_errors, checks, cyc, i;
   integer      seed;

   ppo_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .match_a(ma),
      .match_b(mb), .capture_a(ca), .pulse_out(pout), .pulse_out_en(pen));

   ppo_timer_model tmr (.aclk(aclk), .aresetn(aresetn), .go(go),
      .req_a(ra), .req_b(rb), .req_c(rc), .match_a(ma), .match_b(mb),
      .capture_a(ca));

   always #5 aclk = ~aclk;

   task automatic give_verdict;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit aw_done, w_done;
      aw_done = 0;
      w_done  = 0;
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         if (!aw_done && awready)
         begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready)
         begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, eb});
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      v      = rdata;
      resp   = rresp;
      rready <= 1'b0;
   endtask : rd

   function automatic logic [15:0] pins(input logic [15:0] o,
                                        input logic [7:0] m,
                                        input logic [15:0] e);
      logic [15:0] p;
      for (int g = 0; g < 4; g++)
         p[4*g+:4] = m[4+g] ? o[4*g+:4] : ~o[4*g+:4];
      return p & e;
   endfunction : pins

   // Match A (or capture where chosen) copies all bits; match B in
   // non-overlap mode only clears bits whose next value is zero.
   function automatic logic [15:0] step(input logic [15:0] o, n);
      logic [1:0] ch;
      for (int g = 0; g < 4; g++)
      begin
         ch = ts[2*g+:2];
         if (cm[ch] ? rc[ch] : ra[ch])
            o[4*g+:4] = n[4*g+:4];
         else if (rb[ch] && mode[g])
            o[4*g+:4] = o[4*g+:4] & n[4*g+:4];
      end
      return o;
   endfunction : step

   initial
   begin
      seed = 32'hD31CD2D8;
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 8'h00;
      {awaddr, araddr, wdata, ra, rb, rc} = 60'h0;
      eb = PPO_RESP_OKAY;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(PPO_OFS_MODE, d, r);
      chk("mode_reset", d, 32'h000000F0);
      rd(PPO_OFS_TRIGSEL, d, r);
      chk("trigsel_reset", d, 32'h000000FF);
      rd(8'h20, d, r);
      chk("unmapped_resp", {30'h0, r}, 32'h2);
      // A write to an unmapped offset must be refused with an error.
      eb = PPO_RESP_SLVERR;
      wr(8'h24, 32'h0000_00AA);
      eb = PPO_RESP_OKAY;
      od = 16'h0000;
      for (i = 0; i < 60; i++)
      begin
         rnd  = $random(seed);
         mode = rnd[7:0];
         ts   = rnd[15:8];
         cm   = rnd[19:16];
         rnd  = $random(seed);
         dir  = rnd[15:0] | 16'hF0F0;
         en   = rnd[31:16] | 16'h0FF0;
         rnd  = $random(seed);
         nd   = rnd[15:0];
         d    = $random(seed);
         {ra, rb, rc} = rnd[27:16] & d[11:0];
         if (i < 4)
         begin
            mode = 8'h0F;
            ts   = 8'h00;
            nd   = 16'h9595;
            {ra, rb, rc} = (i[0]) ? 12'h100 : 12'h010;
         end
         wr(PPO_OFS_MODE, {24'h0, mode});
         wr(PPO_OFS_TRIGSEL, {24'h0, ts});
         wr(PPO_OFS_CAPMODE, {28'h0, cm});
         wr(PPO_OFS_DIR, {16'h0, dir});
         wr(PPO_OFS_NDEN, {16'h0, en});
         if (i % 8 == 7)
         begin
            od = rnd[31:16];
            wr(PPO_OFS_OUTDATA, {16'h0, od});
         end
         // Next data is loaded only between triggers.
         wr(PPO_OFS_NEXT, {16'h0, nd});
         repeat (2) @(posedge aclk);
         chk("pin_en", {16'h0, pen}, {16'h0, dir & en});
         x = {16'h0, pins(od, mode, dir & en)};
         chk("pins_held", {16'h0, pout}, x);
         rd(PPO_OFS_PINSTAT, d, r);
         chk("pin_stat", d, x);
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
         repeat (3) @(posedge aclk);
         od = step(od, nd);
         x = {16'h0, pins(od, mode, dir & en)};
         chk("pins_trig", {16'h0, pout}, x);
         rd(PPO_OFS_OUTDATA, d, r);
         chk("out_data", d, {16'h0, od});
      end
      // A second reset in mid-run must restore the reset state.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("pins_reset", {16'h0, pout}, 32'h0);
      rd(PPO_OFS_MODE, d, r);
      chk("mode_reset2", d, 32'h000000F0);
      rd(PPO_OFS_OUTDATA, d, r);
      chk("out_reset", d, 32'h0);
      give_verdict();
   end
endmodule : tb
